// ===== rtl/gpdb_top.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ps
// What this block does
// (RULE1) Edge sets matching flag when interrupt enabled; here only if the pin also routes to line 0 or 1
// (RULE2) Flag clears when its enable written zero
// (RULE3) Software re-enables edge after clearing flag
// (RULE4) Two routing enables per pin, lines 0/1
// (RULE5) Edges and functions use debounced level
// (RULE6) Debounced level readable; writes set time
// (RULE7) Debounce off, or 4/16/64 slow periods
// (RULE8) Sixteen input config registers, reset zero
// (RULE9) Per-pin function select register, reset zero
// (RULE10) Edge detect latches rising and falling edges
// (RULE11) Buffer enable passes pin, else constant
// (RULE12) Polarity bit inverts input before filtering
module gpdb_top #(
  parameter int NUM_PINS = gpdb_pkg::NUM_PINS,
  parameter int SLOW_DIV = gpdb_pkg::SLOW_DIV
) (
  input  wire logic                         clk_sys_i,
  input  wire logic                         srst_i,
  input  wire logic                         psel_i,
  input  wire logic                         penable_i,
  input  wire logic                         pwrite_i,
  input  wire logic [gpdb_pkg::PADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                  pwdata_i,
  input  wire logic [3:0]                   pstrb_i,
  output logic      [31:0]                  prdata_o,
  output logic                              pready_o,
  output logic                              pslverr_o,
  input  wire logic [NUM_PINS-1:0]          pins_i,
  output logic      [NUM_PINS-1:0]          filtered_level_o,
  output logic [NUM_PINS*gpdb_pkg::SEL_W-1:0] function_sel_o,
  output logic                              pin_irq_line0_o,
  output logic                              pin_irq_line1_o,
  output logic                              irq_o
);
  import gpdb_pkg::*;

  localparam int DIV_W = $clog2(SLOW_DIV + 1);

  // Refuse sizes the decoder or divider cannot serve
  if (NUM_PINS < 1 || NUM_PINS > 16 || SLOW_DIV < 2) begin : g_bad
    $error("gpdb_top: unsupported NUM_PINS or SLOW_DIV");
  end

  // Per-pin settings
  logic [NUM_PINS-1:0] route1_q;    // route_to_line1_en
  logic [NUM_PINS-1:0] route0_q;    // route_to_line0_en
  logic [NUM_PINS-1:0] rise_en_q;   // rise_irq_en
  logic [NUM_PINS-1:0] fall_en_q;   // fall_irq_en
  logic [NUM_PINS-1:0] inbuf_q;     // in_buffer_en
  logic [NUM_PINS-1:0] inv_q;       // in_invert
  logic [1:0]          tsel_q [NUM_PINS];  // filter_time_sel
  logic [SEL_W-1:0]    fsel_q [NUM_PINS];  // function_sel
  // Per-pin state
  logic [NUM_PINS-1:0] rise_flag_q; // Sticky rising flag
  logic [NUM_PINS-1:0] fall_flag_q; // Sticky falling flag
  logic [NUM_PINS-1:0] raw_lvl;     // From filters
  logic [NUM_PINS-1:0] filt_lvl;
  logic [NUM_PINS-1:0] rise_evt;
  logic [NUM_PINS-1:0] fall_evt;
  logic [NUM_PINS-1:0] filt_q;      // Output copy
  // Interrupt summary
  logic [1:0]          stat_q;      // Sticky line events
  logic [1:0]          mask_q;      // Interrupt mask
  logic                line0_q;
  logic                line1_q;
  logic                irq_q;
  // Slow tick divider
  logic [DIV_W-1:0]    div_q;
  logic                tick_q;
  // Bus
  logic                pready_q;
  logic                pslverr_q;
  logic [31:0]         prdata_q;
  logic [IDX_W-1:0]    idx;         // Word index
  logic [3:0]          pin_sel;     // Pin within a bank
  logic                wr_fire;     // Write takes effect
  logic [7:0]          rd_byte;
  logic                line0_d;
  logic                line1_d;

  // Classify a word index
  function automatic gpdb_dec_t decode(input logic [IDX_W-1:0] a);
    gpdb_dec_t k;
    k = DEC_NONE;
    if (a[15:4] == CFG_BASE_IDX[15:4] && int'(a[3:0]) < NUM_PINS) begin
      k = DEC_CFG;
    end else if (a[15:4] == FSEL_BASE_IDX[15:4] &&
                 int'(a[3:0]) < NUM_PINS) begin
      k = DEC_FSEL;
    end else if (a == IRQ_STAT_IDX) begin
      k = DEC_STAT;
    end else if (a == IRQ_MASK_IDX) begin
      k = DEC_MASK;
    end
    return k;
  endfunction

  assign idx     = paddr_i[PADDR_W-1:2];
  assign pin_sel = paddr_i[5:2];
  // Effect at the edge where pready is seen high
  assign wr_fire = psel_i & penable_i & pready_q & pwrite_i & pstrb_i[0]
                   & (paddr_i[1:0] == 2'h0);

  // Slow oscillator tick from the system clock
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == DIV_W'(SLOW_DIV - 1)) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // One filter per pin
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    gpdb_pin_if u_if ();
    assign u_if.in_buffer_en    = inbuf_q[i];
    assign u_if.in_invert       = inv_q[i];
    assign u_if.filter_time_sel = tsel_q[i];
    assign raw_lvl[i]  = u_if.raw_level;
    assign filt_lvl[i] = u_if.filtered_level;
    assign rise_evt[i] = u_if.rise_evt;
    assign fall_evt[i] = u_if.fall_evt;
    gpdb_pin_filter u_flt (
      .clk_sys_i   (clk_sys_i),
      .srst_i      (srst_i),
      .pin_i       (pins_i[i]),
      .slow_tick_i (tick_q),
      .pin_if      (u_if.flt)
    );
    assign function_sel_o[i*SEL_W +: SEL_W] = fsel_q[i];
  end

  // (RULE8) input config write, reset to zero
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      route1_q  <= {NUM_PINS{CFG_RST[LINE1_BIT]}};
      route0_q  <= {NUM_PINS{CFG_RST[LINE0_BIT]}};
      rise_en_q <= {NUM_PINS{CFG_RST[RISE_BIT]}};
      fall_en_q <= {NUM_PINS{CFG_RST[FALL_BIT]}};
      inbuf_q   <= {NUM_PINS{CFG_RST[INBUF_BIT]}};
      inv_q     <= {NUM_PINS{CFG_RST[INV_BIT]}};
      for (int i = 0; i < NUM_PINS; i++) begin
        tsel_q[i] <= CFG_RST[TSEL_LSB +: 2];
      end
    end else if (wr_fire && decode(idx) == DEC_CFG) begin
      // (RULE4) two routing enables
      route1_q[pin_sel]  <= pwdata_i[LINE1_BIT];
      route0_q[pin_sel]  <= pwdata_i[LINE0_BIT];
      rise_en_q[pin_sel] <= pwdata_i[RISE_BIT];
      fall_en_q[pin_sel] <= pwdata_i[FALL_BIT];
      inbuf_q[pin_sel]   <= pwdata_i[INBUF_BIT];
      inv_q[pin_sel]     <= pwdata_i[INV_BIT];
      // (RULE6) status bit position holds time code
      tsel_q[pin_sel]    <= pwdata_i[TSEL_LSB +: 2];
    end
  end

  // (RULE9) function select registers
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        fsel_q[i] <= FSEL_RST;
      end
    end else if (wr_fire && decode(idx) == DEC_FSEL) begin
      fsel_q[pin_sel] <= pwdata_i[SEL_W-1:0];
    end
  end

  // Sticky edge flags, set wins over clear
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rise_flag_q <= '0;
      fall_flag_q <= '0;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        // (RULE1) debounced edge on an enabled pin routed to line 0 or 1
        // (RULE3) a cleared enable blocks the next edge
        if (rise_evt[i] && rise_en_q[i] && (route0_q[i] || route1_q[i])) begin
          rise_flag_q[i] <= 1'b1;
        // (RULE2) zero written to rising enable
        end else if (wr_fire && decode(idx) == DEC_CFG &&
                     int'(pin_sel) == i && !pwdata_i[RISE_BIT]) begin
          rise_flag_q[i] <= 1'b0;
        end
        if (fall_evt[i] && fall_en_q[i] && (route0_q[i] || route1_q[i])) begin
          fall_flag_q[i] <= 1'b1;
        // (RULE2) zero written to falling enable
        end else if (wr_fire && decode(idx) == DEC_CFG &&
                     int'(pin_sel) == i && !pwdata_i[FALL_BIT]) begin
          fall_flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // (RULE4) flagged pins drive their routed lines
  assign line0_d = |((rise_flag_q | fall_flag_q) & route0_q);
  assign line1_d = |((rise_flag_q | fall_flag_q) & route1_q);

  // Shared line outputs and debounced levels
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      line0_q <= 1'b0;
      line1_q <= 1'b0;
      filt_q  <= '0;
    end else begin
      line0_q <= line0_d;
      line1_q <= line1_d;
      // (RULE5) peripherals see debounced level
      filt_q  <= filt_lvl;
    end
  end

  // Line events into sticky status, write one clears
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      stat_q <= IRQ_RST;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if ((k == 0) ? (line0_d && !line0_q) : (line1_d && !line1_q)) begin
          // New event beats a clear in the same cycle
          stat_q[k] <= 1'b1;
        end else if (wr_fire && decode(idx) == DEC_STAT && pwdata_i[k]) begin
          stat_q[k] <= 1'b0;
        end
      end
    end
  end

  // Mask register and interrupt output
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mask_q <= IRQ_RST;
      irq_q  <= 1'b0;
    end else begin
      if (wr_fire && decode(idx) == DEC_MASK) begin
        mask_q <= pwdata_i[1:0];
      end
      irq_q <= |(stat_q & mask_q);
    end
  end

  // Read mux
  always_comb begin
    rd_byte = 8'h00;
    if (decode(idx) == DEC_CFG) begin
      // (RULE6) live debounced level readable
      rd_byte[LINE1_BIT] = route1_q[pin_sel];
      rd_byte[LINE0_BIT] = route0_q[pin_sel];
      rd_byte[RISE_BIT]  = rise_flag_q[pin_sel];
      rd_byte[FALL_BIT]  = fall_flag_q[pin_sel];
      rd_byte[INBUF_BIT] = inbuf_q[pin_sel];
      rd_byte[INV_BIT]   = inv_q[pin_sel];
      rd_byte[FILT_BIT]  = filt_lvl[pin_sel];
      rd_byte[RAW_BIT]   = raw_lvl[pin_sel];
    end else if (decode(idx) == DEC_FSEL) begin
      rd_byte = fsel_q[pin_sel];
    end else if (decode(idx) == DEC_STAT) begin
      rd_byte = {6'h00, stat_q};
    end else if (decode(idx) == DEC_MASK) begin
      rd_byte = {6'h00, mask_q};
    end
  end

  // APB answer: one wait cycle, then pready
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (psel_i && penable_i && !pready_q) begin
      pready_q  <= 1'b1;
      // Unmapped or misaligned address errors
      pslverr_q <= (decode(idx) == DEC_NONE) || (paddr_i[1:0] != 2'h0);
      // Refused reads return zero along with the error
      prdata_q  <= (pwrite_i || paddr_i[1:0] != 2'h0) ? 32'h0000_0000
                                                      : {24'h00_0000, rd_byte};
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  assign prdata_o         = prdata_q;
  assign pready_o         = pready_q;
  assign pslverr_o        = pslverr_q;
  assign filtered_level_o = filt_q;
  assign pin_irq_line0_o  = line0_q;
  assign pin_irq_line1_o  = line1_q;
  assign irq_o            = irq_q;

endmodule

// ===== inc/gpdb_pkg.sv
// Shared constants for the pin input conditioning block
package gpdb_pkg;

  // Clock rates and the slow tick divider
  localparam int SYS_CLK_HZ  = 50_000_000;
  localparam int SLOW_OSC_HZ = 32_000;
  // Longest whole period of the slow rate, in system cycles
  localparam int SLOW_DIV    = SYS_CLK_HZ / SLOW_OSC_HZ;

  // Port size and bus geometry
  localparam int NUM_PINS = 16;
  localparam int PADDR_W  = 18;
  localparam int IDX_W    = 16;
  localparam int SEL_W    = 8;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] CFG_BASE_IDX  = 16'hA110;
  localparam logic [IDX_W-1:0] FSEL_BASE_IDX = 16'hA120;
  localparam logic [IDX_W-1:0] IRQ_STAT_IDX  = 16'hA130;
  localparam logic [IDX_W-1:0] IRQ_MASK_IDX  = 16'hA131;

  // Field positions in pin_input_config
  localparam int LINE1_BIT  = 7;
  localparam int LINE0_BIT  = 6;
  localparam int RISE_BIT   = 5;
  localparam int FALL_BIT   = 4;
  localparam int INBUF_BIT  = 3;
  localparam int INV_BIT    = 2;
  localparam int FILT_BIT   = 1;
  localparam int RAW_BIT    = 0;
  localparam int TSEL_LSB   = 0;

  // Reset values
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [7:0] FSEL_RST = 8'h00;
  localparam logic [1:0] IRQ_RST  = 2'h0;

  // Filter time codes and stable periods
  localparam logic [1:0] TSEL_OFF = 2'h0;
  localparam logic [1:0] TSEL_4   = 2'h1;
  localparam logic [1:0] TSEL_16  = 2'h2;
  localparam int         CNT_W    = 7;
  localparam logic [CNT_W-1:0] PER_4  = 7'h04;
  localparam logic [CNT_W-1:0] PER_16 = 7'h10;
  localparam logic [CNT_W-1:0] PER_64 = 7'h40;

  // Register classes seen by the address decoder
  typedef enum {DEC_NONE, DEC_CFG, DEC_FSEL, DEC_STAT, DEC_MASK} gpdb_dec_t;

endpackage

// ===== inc/gpdb_pin_if.sv
`timescale 1ns/1ps
// One pin's settings and conditioned levels
interface gpdb_pin_if;
  logic       in_buffer_en;    // Input buffer on
  logic       in_invert;       // Invert pin level
  logic [1:0] filter_time_sel; // Debounce time code
  logic       raw_level;       // Buffer output, unfiltered
  logic       filtered_level;  // Debounced level
  logic       rise_evt;        // One-cycle rising edge
  logic       fall_evt;        // One-cycle falling edge

  // Register side
  modport ctl (output in_buffer_en, in_invert, filter_time_sel,
               input  raw_level, filtered_level, rise_evt, fall_evt);
  // Filter side
  modport flt (input  in_buffer_en, in_invert, filter_time_sel,
               output raw_level, filtered_level, rise_evt, fall_evt);
endinterface

// ===== rtl/gpdb_pin_filter.sv
`timescale 1ns/1ps
// Synchroniser, buffer gate, polarity, debounce and edge detect
module gpdb_pin_filter (
  input  wire logic clk_sys_i,
  input  wire logic srst_i,
  input  wire logic pin_i,
  input  wire logic slow_tick_i,
  gpdb_pin_if.flt   pin_if
);
  import gpdb_pkg::*;

  logic             sync1_q;  // First stage, read by sync2 only
  logic             sync2_q;  // Second stage
  logic             raw_q;    // Buffer output
  logic             filt_q;   // Debounced level
  logic             prev_q;   // Debounced level, one cycle late
  logic [CNT_W-1:0] cnt_q;    // Stable slow periods so far
  logic             cond;     // Conditioned input
  logic [CNT_W-1:0] limit;    // Periods required

  // Two-stage synchroniser on the pin
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
    end
  end

  // (RULE11) buffer gate, constant zero when off
  // (RULE12) polarity applied before filtering
  assign cond = (sync2_q & pin_if.in_buffer_en) ^ pin_if.in_invert;

  // Raw buffer status
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      raw_q <= 1'b0;
    end else begin
      raw_q <= sync2_q & pin_if.in_buffer_en;
    end
  end

  // (RULE7) time code to stable periods
  always_comb begin
    case (pin_if.filter_time_sel)
      TSEL_4:  limit = PER_4;
      TSEL_16: limit = PER_16;
      default: limit = PER_64;
    endcase
  end

  // (RULE7) debounce counter on slow ticks
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      filt_q <= 1'b0;
      cnt_q  <= '0;
    end else if (pin_if.filter_time_sel == TSEL_OFF) begin
      // Filter off, follow input
      filt_q <= cond;
      cnt_q  <= '0;
    end else if (cond == filt_q) begin
      // Level back, restart wait
      cnt_q <= '0;
    end else if (slow_tick_i) begin
      if (cnt_q + 7'h01 >= limit) begin
        filt_q <= cond;
        cnt_q  <= '0;
      end else begin
        cnt_q <= cnt_q + 7'h01;
      end
    end
  end

  // Delayed copy for edge detection
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= filt_q;
    end
  end

  assign pin_if.raw_level      = raw_q;
  assign pin_if.filtered_level = filt_q;
  // (RULE10) edge latches fed from debounced level
  assign pin_if.rise_evt = filt_q & ~prev_q;
  assign pin_if.fall_evt = ~filt_q & prev_q;

endmodule

// ===== tb/gpdb_top_asserts.sv
`timescale 1ns/1ps
// Port-level checks for the pin input block
module gpdb_top_asserts #(
  parameter int NUM_PINS = 16
) (
  input wire logic                                clk_sys_i,
  input wire logic                                srst_i,
  input wire logic                                psel_i,
  input wire logic                                penable_i,
  input wire logic                                pwrite_i,
  input wire logic [gpdb_pkg::PADDR_W-1:0]        paddr_i,
  input wire logic [31:0]                         pwdata_i,
  input wire logic [3:0]                          pstrb_i,
  input wire logic [31:0]                         prdata_o,
  input wire logic                                pready_o,
  input wire logic                                pslverr_o,
  input wire logic [NUM_PINS-1:0]                 pins_i,
  input wire logic [NUM_PINS-1:0]                 filtered_level_o,
  input wire logic [NUM_PINS*gpdb_pkg::SEL_W-1:0] function_sel_o,
  input wire logic                                pin_irq_line0_o,
  input wire logic                                pin_irq_line1_o,
  input wire logic                                irq_o
);
  import gpdb_pkg::*;
  logic wr_done; // Write completing at this edge
  assign wr_done = psel_i && penable_i && pwrite_i && pready_o;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  a_ready_pulse: assert property (
    pready_o |=> !pready_o) else $error("ready held over one cycle");
  a_ready_wait: assert property (
    psel_i && penable_i && !pready_o |=> pready_o)
    else $error("no answer in second access cycle");
  a_ready_cause: assert property (
    pready_o |-> psel_i && penable_i && $past(penable_i))
    else $error("ready outside an access phase");
  a_err_zero: assert property (
    pslverr_o |-> pready_o && (pwrite_i || prdata_o == 32'h0000_0000))
    else $error("error without ready or with data");
  a_upper_zero: assert property (
    pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_line0_clear: assert property (
    $fell(pin_irq_line0_o) && !$past(srst_i) && !$past(srst_i, 2)
    |-> $past(wr_done, 2)) else $error("line 0 fell without a write");
  a_line1_clear: assert property (
    $fell(pin_irq_line1_o) && !$past(srst_i) && !$past(srst_i, 2)
    |-> $past(wr_done, 2)) else $error("line 1 fell without a write");
  a_irq_clear: assert property (
    $fell(irq_o) && !$past(srst_i) && !$past(srst_i, 2)
    |-> $past(wr_done, 2)) else $error("irq fell without a write");
  a_fsel_write: assert property (
    !$stable(function_sel_o) && !$past(srst_i) && !$past(srst_i, 2)
    |-> $past(wr_done) || $past(wr_done, 2))
    else $error("function select moved without a write");

  // Main scenarios reached
  c_write: cover property (wr_done);
  c_line0: cover property ($rose(pin_irq_line0_o));
  c_line1: cover property ($rose(pin_irq_line1_o));
  c_error: cover property (pslverr_o);
endmodule

bind gpdb_top gpdb_top_asserts #(.NUM_PINS(NUM_PINS)) u_asserts (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .pins_i(pins_i),
  .filtered_level_o(filtered_level_o), .function_sel_o(function_sel_o),
  .pin_irq_line0_o(pin_irq_line0_o), .pin_irq_line1_o(pin_irq_line1_o),
  .irq_o(irq_o));

// ===== tb/gpdb_pin_model.sv
`timescale 1ns/1ps
// Outside world at the pins: steady levels plus short glitches
module gpdb_pin_model (
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] level_i,  // Settled pin levels
  input  wire logic [15:0] glitch_i, // Pins to flip for now
  output logic      [15:0] pins_o    // Levels seen by the block
);
  // Pins move just after the clock, like a board signal
  always_ff @(posedge clk_sys_i) begin
    pins_o <= level_i ^ glitch_i;
  end
endmodule

// ===== tb/gpdb_top_test.sv
`timescale 1ns/1ps
// Register-level test of the pin input block
module gpdb_top_test;
  import gpdb_pkg::*;
  localparam int DIV = 4; // Short slow tick for the run
  localparam logic [17:0] STAT_A = 18'h2_84C0;
  localparam logic [17:0] MASK_A = 18'h2_84C4;
  localparam logic [17:0] FSEL_A = 18'h2_8480;
  localparam logic [17:0] BAD_A  = 18'h2_8500; // Unmapped word
  localparam logic [7:0]  CFGW [4] = '{8'h08, 8'h0C, 8'h00, 8'h04};
  localparam logic [7:0]  CFGR [4] = '{8'h0B, 8'h0D, 8'h00, 8'h06};
  localparam int          PER [4]  = '{0, 4, 16, 64};
  logic         clk_sys_i, srst_i, psel, penable, pwrite, pready_o;
  logic         pslverr_o, irq_o, line0, line1, rerr;
  logic [17:0]  paddr;
  logic [31:0]  pwdata, prdata_o, rdata;
  logic [15:0]  level, glitch, pins, filt;
  logic [127:0] fsel;
  logic [7:0]   rt;
  int           miscompares, checks_done;

  always #10 clk_sys_i = ~clk_sys_i;

  gpdb_pin_model PINS (.clk_sys_i(clk_sys_i), .level_i(level),
    .glitch_i(glitch), .pins_o(pins));
  gpdb_top #(.SLOW_DIV(DIV)) DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .pins_i(pins), .filtered_level_o(filt), .function_sel_o(fsel),
    .pin_irq_line0_o(line0), .pin_irq_line1_o(line1), .irq_o(irq_o));

  // Compare and count
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; waits for the slave's answer
  task automatic apb(input logic w, input logic [17:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
    end while (pready_o !== 1'b1);
    rdata = prdata_o;
    rerr = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  function automatic logic [17:0] cfg(input int n);
    return 18'h2_8440 + 18'(4 * n);
  endfunction

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog well past the expected run
  initial begin
    wt(20000);
    miscompares++;
    finish_test;
  end

  initial begin
    clk_sys_i = 1'b0;
    srst_i = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {level, glitch, miscompares, checks_done} = '0;
    wt(10);
    srst_i <= 1'b0;
    // Reset values, unmapped word, function select
    apb(0, cfg(0), 0); check("cfg0 reset", rdata, 0);
    apb(0, cfg(15), 0); check("cfg15 reset", rdata, 0);
    apb(0, FSEL_A + 18'd12, 0); check("fsel3 reset", rdata, 0);
    apb(0, BAD_A, 0); check("unmapped err", rerr, 1);
    apb(1, FSEL_A + 18'd20, 32'h0000_00A5);
    apb(0, FSEL_A + 18'd20, 0); check("fsel5", rdata, 8'hA5);
    check("fsel5 out", fsel[47:40], 8'hA5);
    $display("Test registers done");
    // Buffer gate and polarity, pin 0 held high
    level[0] <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1, cfg(0), CFGW[i]);
      wt(10);
      apb(0, cfg(0), 0); check("cfg0 levels", rdata, CFGR[i]);
      check("filt0 out", filt[0], CFGR[i][1]);
    end
    $display("Test buffer done");
    // Misaligned read of a live register is refused with zero data
    apb(0, cfg(0) + 18'd1, 0); check("misaligned err", rerr, 1);
    check("misaligned data", rdata, 0);
    // Edges, flags and routing on each line
    for (int k = 0; k < 2; k++) begin
      rt = k ? 8'h80 : 8'h40;
      apb(1, cfg(0), 8'h08);
      level[0] <= 1'b0;
      wt(10);
      apb(1, cfg(0), rt | 8'h38);
      apb(1, MASK_A, 3);
      apb(0, MASK_A, 0); check("mask", rdata, 3);
      level[0] <= 1'b1;
      wt(10);
      apb(0, cfg(0), 0); check("rise flag", rdata, rt | 8'h2B);
      check("line0", line0, k == 0);
      check("line1", line1, k == 1);
      apb(0, STAT_A, 0); check("status", rdata, 1 << k);
      apb(1, MASK_A, 0);
      wt(3); check("irq masked", irq_o, 0);
      apb(1, MASK_A, 3);
      wt(3); check("irq on", irq_o, 1);
      level[0] <= 1'b0;
      wt(10);
      apb(0, cfg(0), 0); check("both flags", rdata, rt | 8'h38);
      apb(1, cfg(0), rt | 8'h18);
      apb(0, cfg(0), 0); check("rise cleared", rdata, rt | 8'h18);
      apb(1, cfg(0), rt | 8'h08);
      wt(3); check("line off", line0 | line1, 0);
      apb(1, STAT_A, 1 << k);
      wt(3); check("irq cleared", irq_o, 0);
      level[0] <= 1'b1;
      wt(10);
      apb(0, cfg(0), 0); check("no rearm", rdata, rt | 8'h0B);
      apb(1, cfg(0), rt | 8'h28);
      level[0] <= 1'b0;
      wt(10);
      level[0] <= 1'b1;
      wt(10);
      apb(0, cfg(0), 0); check("rearmed", rdata, rt | 8'h2B);
      apb(1, STAT_A, 3);
    end
    $display("Test edges done");
    // Debounce codes on pin 1: short glitch refused, long level taken
    for (int c = 0; c < 4; c++) begin
      apb(1, cfg(1), 8'h08 | c);
      level[1] <= 1'b0;
      wt(300);
      if (c != 0) begin
        glitch[1] <= 1'b1;
        wt((PER[c] - 2) * DIV);
        glitch[1] <= 1'b0;
        wt(20); check("glitch", filt[1], 0);
      end
      level[1] <= 1'b1;
      if (c == 0) begin
        wt(8); check("no filter", filt[1], 1);
      end else begin
        wt((PER[c] - 2) * DIV); check("early", filt[1], 0);
        wt(4 * DIV + 10); check("settled", filt[1], 1);
      end
    end
    $display("Test debounce done");
    finish_test;
  end
endmodule
